// File: common/lec_pkg.sv
package lec_pkg;

  // Feedback equalizer geometry
  localparam int NTAP = 5;
  localparam int TAP_STEP_MV = 7;
  localparam logic signed [6:0] TAP1_MAX = 7'sh1F;
  localparam logic signed [6:0] TAPN_MAX = 7'sh0F;
  // Slicer target amplitude used by sign-sign adaptation
  localparam logic signed [11:0] DEC_REF_MV = 12'sh064;

  // Transmit filter coefficient limits
  localparam logic signed [6:0] FIR_MAIN_MAX = 7'sh1F;
  localparam logic signed [6:0] FIR_SIDE_MAX = 7'sh0F;

  // Rate window, counted in calibration clock ticks
  localparam logic [15:0] PPM_WIN_TICKS = 16'h0400;
  localparam logic [15:0] PPM_TOL = 16'h0008;
  // Expected bit counts per window for each rate table entry
  localparam logic [3:0][15:0] RATE_TBL = {16'h0800, 16'h0600, 16'h0400, 16'h0200};

  localparam logic [6:0] PRBS_SEED = 7'h7F;

  typedef enum logic [1:0] {
    LEC_DFE_OFF = 2'h0,
    LEC_DFE_T12 = 2'h1,
    LEC_DFE_ALL = 2'h3
  } lec_dfe_lvl_t;

  typedef enum logic [1:0] {
    LEC_AD_OFF = 2'h0,
    LEC_AD_ACQ = 2'h1,
    LEC_AD_CONT = 2'h3
  } lec_adapt_t;

  typedef enum logic [1:0] {
    LEC_OSEL_RETIMED = 2'h0,
    LEC_OSEL_RAW = 2'h1,
    LEC_OSEL_PRBS = 2'h2,
    LEC_OSEL_MUTE = 2'h3
  } lec_osel_t;

  typedef enum logic {
    LEC_ST_ACQ = 1'b0,
    LEC_ST_LOCK = 1'b1
  } lec_lock_t;

  typedef struct packed {
    logic [4:0] pol;
    logic [4:0][4:0] wt;
  } lec_dfe_man_t;

  typedef struct packed {
    logic signed [4:0] pre;
    logic signed [5:0] main;
    logic signed [4:0] post;
  } lec_fir_t;

  typedef struct packed {
    logic bit_val;
    logic signed [7:0] level;
  } lec_out_t;

endpackage : lec_pkg

// File: verilog/lec_lane.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Feedback equalizer stays off until software enables it, in any adapt mode.
// - Enabled equalizer adapts only during acquisition, or continuously.
// - Enable levels: taps 1-5, taps 1-2 only, or none.
// - Each tap feeds back one bit later than the previous, own weight and polarity.
// - Tap one weight 0-31, taps two to five 0-15, step about 7 mV.
// - Polarity 0 gives positive low-pass feedback, 1 negative high-pass feedback.
// - Output selector: retimed, raw, pattern generator, or muted.
// - Default path: equalized data, recovered, then into transmit filter.
// - Software may steer recovered data into the pattern checker.
// - Calibration clock only drives the rate window counter, never recovery.
// - Rate counter limits lock to the programmed table or manual rate.
// - Transmit output is a weighted sum of three consecutive selected bits, forced to zero when muted.
// - Main coefficient -31..+31, pre and post coefficients -15..15.
// - Pre-cursor weights the bit before a transition, post-cursor the bit after.
module lec_lane (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Equalized sample stream from the front end
  input wire logic in_valid_i,
  input wire logic signed [9:0] in_sample_i,
  output logic in_ready_o,
  // Filtered stream to the output driver
  output logic out_valid_o,
  input wire logic out_ready_i,
  output lec_pkg::lec_out_t out_word_o,
  // Feedback equalizer control
  input wire logic dfe_en_i,
  input wire lec_pkg::lec_dfe_lvl_t dfe_level_i,
  input wire lec_pkg::lec_adapt_t dfe_adapt_i,
  input wire lec_pkg::lec_dfe_man_t dfe_man_i,
  output logic [4:0][5:0] dfe_coef_o,
  // Recovery path control
  input wire lec_pkg::lec_osel_t out_sel_i,
  input wire logic chk_en_i,
  output logic [15:0] chk_err_cnt_o,
  // Rate window
  input wire logic cal_tick_i,
  input wire logic [1:0] rate_sel_i,
  input wire logic rate_man_en_i,
  input wire logic [15:0] rate_man_cnt_i,
  output logic [15:0] ppm_cnt_o,
  output logic lock_o,
  // Transmit filter
  input wire lec_pkg::lec_fir_t fir_coef_i
);

  function automatic logic signed [6:0] sat7(input logic signed [7:0] v,
                                            input logic signed [6:0] lim);
    if (v > 8'(lim)) begin
      sat7 = lim;
    end else if (v < -8'(lim)) begin
      sat7 = -lim;
    end else begin
      sat7 = v[6:0];
    end
  endfunction : sat7

  // Decision history, bit 0 is the newest decision
  logic [6:0] dhist_ff, nxt_dhist;
  logic [4:0][5:0] coef_ff, nxt_coef;
  logic [1:0] txh_ff, nxt_txh;
  logic [6:0] prbs_ff, nxt_prbs;
  logic [15:0] chk_ff, nxt_chk;
  logic [15:0] win_ff, nxt_win;
  logic [15:0] bitcnt_ff, nxt_bitcnt;
  logic [15:0] ppm_ff, nxt_ppm;
  lec_pkg::lec_lock_t lock_ff, nxt_lock;
  lec_pkg::lec_out_t head_ff, nxt_head;
  lec_pkg::lec_out_t skid_ff, nxt_skid;
  logic hv_ff, nxt_hv;
  logic sv_ff, nxt_sv;
  logic rdy_ff, nxt_rdy;

  logic push;
  logic pop;
  logic dfe_on;
  logic adapt_on;
  logic [4:0] tap_act;
  logic signed [11:0] fb;
  logic signed [11:0] eq;
  logic signed [11:0] err;
  logic dec;
  logic raw_bit;
  logic prbs_bit;
  logic tx_bit;
  logic signed [7:0] fir_sum;
  lec_pkg::lec_out_t word;

  assign push = in_valid_i && rdy_ff;
  assign pop = hv_ff && out_ready_i;

  // Equalizer, slicer and output selection
  always_comb begin
    logic signed [11:0] term;
    logic signed [6:0] c;
    term = '0;
    c = '0;
    dfe_on = dfe_en_i && (dfe_level_i != lec_pkg::LEC_DFE_OFF);
    adapt_on = dfe_on && ((dfe_adapt_i == lec_pkg::LEC_AD_CONT) ||
                          ((dfe_adapt_i == lec_pkg::LEC_AD_ACQ) &&
                           (lock_ff == lec_pkg::LEC_ST_ACQ)));
    fb = '0;
    for (int k = 0; k < lec_pkg::NTAP; k++) begin
      // Taps 3-5 only join at the full level, trading power for reach
      tap_act[k] = dfe_on && ((k < 2) || (dfe_level_i == lec_pkg::LEC_DFE_ALL));
      c = 7'($signed(coef_ff[k]));
      term = 12'(c) * 12'(lec_pkg::TAP_STEP_MV);
      // Tap k looks at the decision k+1 bits back
      if (tap_act[k]) begin
        fb = dhist_ff[k] ? 12'(fb + term) : 12'(fb - term);
      end
    end
    // Positive code adds the past bit (low-pass), negative subtracts it (high-pass)
    eq = 12'(12'(in_sample_i) + fb);
    dec = ~eq[11];
    raw_bit = ~in_sample_i[9];
    err = dec ? 12'(eq - lec_pkg::DEC_REF_MV) : 12'(eq + lec_pkg::DEC_REF_MV);
    prbs_bit = prbs_ff[6] ^ prbs_ff[5];
    case (out_sel_i)
      lec_pkg::LEC_OSEL_RETIMED: tx_bit = dec;
      lec_pkg::LEC_OSEL_RAW: tx_bit = raw_bit;
      lec_pkg::LEC_OSEL_PRBS: tx_bit = prbs_bit;
      lec_pkg::LEC_OSEL_MUTE: tx_bit = 1'b0;
      default: tx_bit = dec;
    endcase
  end

  // Transmit filter: the incoming bit is the next bit, txh holds current and previous
  always_comb begin
    logic signed [6:0] cpre;
    logic signed [6:0] cmain;
    logic signed [6:0] cpost;
    cpre = sat7(8'(fir_coef_i.pre), lec_pkg::FIR_SIDE_MAX);
    cmain = sat7(8'(fir_coef_i.main), lec_pkg::FIR_MAIN_MAX);
    cpost = sat7(8'(fir_coef_i.post), lec_pkg::FIR_SIDE_MAX);
    // Width covers 61 so an oversized coefficient set cannot wrap
    fir_sum = '0;
    fir_sum = tx_bit ? 8'(fir_sum + 8'(cpre)) : 8'(fir_sum - 8'(cpre));
    fir_sum = txh_ff[0] ? 8'(fir_sum + 8'(cmain)) : 8'(fir_sum - 8'(cmain));
    fir_sum = txh_ff[1] ? 8'(fir_sum + 8'(cpost)) : 8'(fir_sum - 8'(cpost));
    word.bit_val = txh_ff[0];
    word.level = (out_sel_i == lec_pkg::LEC_OSEL_MUTE) ? 8'sh00 : fir_sum;
  end

  // Tap coefficients, history and pattern logic
  always_comb begin
    logic signed [6:0] lim;
    logic signed [7:0] upd;
    logic signed [7:0] man;
    lim = '0;
    upd = '0;
    man = '0;
    nxt_coef = coef_ff;
    nxt_dhist = dhist_ff;
    nxt_txh = txh_ff;
    nxt_prbs = prbs_ff;
    nxt_chk = chk_ff;
    for (int k = 0; k < lec_pkg::NTAP; k++) begin
      lim = (k == 0) ? lec_pkg::TAP1_MAX : lec_pkg::TAPN_MAX;
      man = dfe_man_i.pol[k] ? -8'(dfe_man_i.wt[k]) : 8'(dfe_man_i.wt[k]);
      if (!adapt_on) begin
        // Hand settings only take effect while adaptation is off
        nxt_coef[k] = 6'(sat7(man, lim));
      end else if (push && tap_act[k]) begin
        // Sign-sign step: pull the error toward zero, one code per bit
        upd = (err[11] ^ ~dhist_ff[k]) ? 8'(8'($signed(coef_ff[k])) + 8'sh01)
                                       : 8'(8'($signed(coef_ff[k])) - 8'sh01);
        nxt_coef[k] = 6'(sat7(upd, lim));
      end
    end
    if (push) begin
      nxt_dhist = {dhist_ff[5:0], dec};
      nxt_txh = {txh_ff[0], tx_bit};
      if (out_sel_i == lec_pkg::LEC_OSEL_PRBS) begin
        nxt_prbs = {prbs_ff[5:0], prbs_bit};
      end
      // Self-synchronising check on the recovered decisions
      if (chk_en_i && (dec != (dhist_ff[6] ^ dhist_ff[5])) && (chk_ff != 16'hFFFF)) begin
        nxt_chk = 16'(chk_ff + 16'h0001);
      end
    end
    if (!chk_en_i) begin
      nxt_chk = 16'h0000;
    end
  end

  // Rate window counter, paced only by calibration ticks
  always_comb begin
    logic [15:0] expect_cnt;
    logic [15:0] diff;
    logic [15:0] cnt;
    expect_cnt = rate_man_en_i ? rate_man_cnt_i : lec_pkg::RATE_TBL[rate_sel_i];
    cnt = push ? 16'(bitcnt_ff + 16'h0001) : bitcnt_ff;
    diff = (cnt > expect_cnt) ? 16'(cnt - expect_cnt) : 16'(expect_cnt - cnt);
    nxt_bitcnt = cnt;
    nxt_win = win_ff;
    nxt_ppm = ppm_ff;
    nxt_lock = lock_ff;
    if (cal_tick_i) begin
      if (win_ff == 16'(lec_pkg::PPM_WIN_TICKS - 16'h0001)) begin
        nxt_win = 16'h0000;
        nxt_bitcnt = 16'h0000;
        nxt_ppm = cnt;
        case (lock_ff)
          lec_pkg::LEC_ST_ACQ: begin
            if (diff <= lec_pkg::PPM_TOL) begin
              nxt_lock = lec_pkg::LEC_ST_LOCK;
            end
          end
          lec_pkg::LEC_ST_LOCK: begin
            if (diff > lec_pkg::PPM_TOL) begin
              nxt_lock = lec_pkg::LEC_ST_ACQ;
            end
          end
          default: nxt_lock = lec_pkg::LEC_ST_ACQ;
        endcase
      end else begin
        nxt_win = 16'(win_ff + 16'h0001);
      end
    end
  end

  // Two-entry buffer; head is the output register, skid absorbs one stall
  always_comb begin
    nxt_head = head_ff;
    nxt_skid = skid_ff;
    nxt_hv = hv_ff;
    nxt_sv = sv_ff;
    if (pop) begin
      if (sv_ff) begin
        nxt_head = skid_ff;
        nxt_sv = push;
        if (push) begin
          nxt_skid = word;
        end
      end else begin
        nxt_hv = push;
        if (push) begin
          nxt_head = word;
        end
      end
    end else if (push) begin
      if (!hv_ff) begin
        nxt_head = word;
        nxt_hv = 1'b1;
      end else begin
        nxt_skid = word;
        nxt_sv = 1'b1;
      end
    end
    nxt_rdy = ~nxt_sv;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dhist_ff <= 7'h00;
      coef_ff <= '0;
      txh_ff <= 2'h0;
      prbs_ff <= lec_pkg::PRBS_SEED;
      chk_ff <= 16'h0000;
      win_ff <= 16'h0000;
      bitcnt_ff <= 16'h0000;
      ppm_ff <= 16'h0000;
      lock_ff <= lec_pkg::LEC_ST_ACQ;
      head_ff <= '0;
      skid_ff <= '0;
      hv_ff <= 1'b0;
      sv_ff <= 1'b0;
      rdy_ff <= 1'b0;
    end else begin
      dhist_ff <= nxt_dhist;
      coef_ff <= nxt_coef;
      txh_ff <= nxt_txh;
      prbs_ff <= nxt_prbs;
      chk_ff <= nxt_chk;
      win_ff <= nxt_win;
      bitcnt_ff <= nxt_bitcnt;
      ppm_ff <= nxt_ppm;
      lock_ff <= nxt_lock;
      head_ff <= nxt_head;
      skid_ff <= nxt_skid;
      hv_ff <= nxt_hv;
      sv_ff <= nxt_sv;
      rdy_ff <= nxt_rdy;
    end
  end

  assign in_ready_o = rdy_ff;
  assign out_valid_o = hv_ff;
  assign out_word_o = head_ff;
  assign dfe_coef_o = coef_ff;
  assign chk_err_cnt_o = chk_ff;
  assign ppm_cnt_o = ppm_ff;
  assign lock_o = lock_ff;

endmodule : lec_lane
`default_nettype wire

// File: bench/lec_lane_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lec_lane_chk (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Stream
  input wire logic in_valid_i,
  input wire logic in_ready_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire lec_pkg::lec_out_t out_word_o,
  // Control and status
  input wire logic dfe_en_i,
  input wire lec_pkg::lec_adapt_t dfe_adapt_i,
  input wire lec_pkg::lec_dfe_man_t dfe_man_i,
  input wire logic [4:0][5:0] dfe_coef_o,
  input wire lec_pkg::lec_osel_t out_sel_i,
  input wire logic cal_tick_i,
  input wire logic [1:0] rate_sel_i,
  input wire logic rate_man_en_i,
  input wire logic [15:0] rate_man_cnt_i,
  input wire logic [15:0] ppm_cnt_o,
  input wire logic lock_o
);
  logic [15:0] exp_cnt;
  logic [5:0] man1;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  assign exp_cnt = rate_man_en_i ? rate_man_cnt_i : lec_pkg::RATE_TBL[rate_sel_i];
  assign man1 = dfe_man_i.pol[0] ? -{1'b0, dfe_man_i.wt[0]} : {1'b0, dfe_man_i.wt[0]};
  sequence s_push; in_valid_i && in_ready_o; endsequence
  sequence s_stall; out_valid_o && !out_ready_i; endsequence
  a_reset_clear: assert property ($fell(srst_i) |-> !in_ready_o && !out_valid_o && !lock_o)
    else $error("outputs not cleared by reset");
  a_word_hold: assert property (s_stall |=> out_valid_o && $stable(out_word_o))
    else $error("word lost during stall");
  a_full_hold: assert property (s_stall ##0 !in_ready_o |=> !in_ready_o)
    else $error("full buffer took a sample");
  a_mute_zero: assert property (
    s_push ##0 (out_sel_i == lec_pkg::LEC_OSEL_MUTE && !out_valid_o)
    |=> out_word_o.level == 8'sh00)
    else $error("muted word not zero");
  // Hand settings only apply while adaptation is idle
  a_tap1_manual: assert property (
    (dfe_adapt_i == lec_pkg::LEC_AD_OFF || !dfe_en_i) && !$past(srst_i)
    |=> dfe_coef_o[0] == $past(man1))
    else $error("tap one coefficient wrong");
  a_tap2_clamp: assert property (dfe_coef_o[1][5] ? dfe_coef_o[1] >= 6'h31 : dfe_coef_o[1] <= 6'h0F)
    else $error("tap two out of range");
  a_ppm_tick: assert property (
    !$past(srst_i) && ($changed(ppm_cnt_o) || $changed(lock_o))
    |-> $past(cal_tick_i))
    else $error("rate result moved without a tick");
  a_lock_tol: assert property ($rose(lock_o) |->
    ppm_cnt_o <= exp_cnt + lec_pkg::PPM_TOL && exp_cnt <= ppm_cnt_o + lec_pkg::PPM_TOL)
    else $error("lock outside rate window");
endmodule : lec_lane_chk
bind lec_lane lec_lane_chk u_chk (
  .sys_clk_i(sys_clk_i),
  .srst_i(srst_i),
  .in_valid_i(in_valid_i),
  .in_ready_o(in_ready_o),
  .out_valid_o(out_valid_o),
  .out_ready_i(out_ready_i),
  .out_word_o(out_word_o),
  .dfe_en_i(dfe_en_i),
  .dfe_adapt_i(dfe_adapt_i),
  .dfe_man_i(dfe_man_i),
  .dfe_coef_o(dfe_coef_o),
  .out_sel_i(out_sel_i),
  .cal_tick_i(cal_tick_i),
  .rate_sel_i(rate_sel_i),
  .rate_man_en_i(rate_man_en_i),
  .rate_man_cnt_i(rate_man_cnt_i),
  .ppm_cnt_o(ppm_cnt_o),
  .lock_o(lock_o)
);
`default_nettype wire

// File: bench/lec_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module lec_rx_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Receiver side
  input wire logic stall_i,
  input wire logic valid_i,
  input wire lec_pkg::lec_out_t word_i,
  output logic ready_o
);
  lec_pkg::lec_out_t got[$];
  // A slow receiver only withholds ready, so nothing may be dropped upstream
  assign ready_o = !stall_i;
  always @(posedge clk_i) begin
    if (!srst_i && valid_i && ready_o) begin
      got.push_back(word_i);
    end
  end
endmodule : lec_rx_model
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic in_valid_i = 1'b0;
  logic signed [9:0] in_sample_i = '0;
  logic in_ready_o, out_valid_o, out_ready_i, lock_o;
  lec_pkg::lec_out_t out_word_o;
  logic dfe_en_i = 1'b0;
  lec_pkg::lec_dfe_lvl_t dfe_level_i = lec_pkg::LEC_DFE_ALL;
  lec_pkg::lec_adapt_t dfe_adapt_i = lec_pkg::LEC_AD_OFF;
  // Taps 1 and 5 negative, all weights at code maximum
  lec_pkg::lec_dfe_man_t dfe_man_i = {5'h11, 25'h1FFFFFF};
  logic [4:0][5:0] dfe_coef_o;
  lec_pkg::lec_osel_t out_sel_i = lec_pkg::LEC_OSEL_RETIMED;
  logic chk_en_i = 1'b0;
  logic [15:0] chk_err_cnt_o, ppm_cnt_o;
  logic cal_tick_i = 1'b0;
  logic [1:0] rate_sel_i = 2'h0;
  logic rate_man_en_i = 1'b0;
  logic [15:0] rate_man_cnt_i = 16'h0800;
  lec_pkg::lec_fir_t fir_coef_i = '0;
  logic stall = 1'b0;
  logic h1 = 1'b0;
  logic h2 = 1'b0;
  // Pattern generator model, advanced only by pushes in pattern mode
  logic [6:0] pq = lec_pkg::PRBS_SEED;
  // Pushes since the rate window last restarted
  int pend = 0;
  int n_mismatch = 0;
  int checked = 0;
  int lq[$];
  logic bq[$];
  always #25 sys_clk_i = ~sys_clk_i;
  lec_lane uut (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .in_valid_i(in_valid_i),
    .in_sample_i(in_sample_i),
    .in_ready_o(in_ready_o),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_word_o(out_word_o),
    .dfe_en_i(dfe_en_i),
    .dfe_level_i(dfe_level_i),
    .dfe_adapt_i(dfe_adapt_i),
    .dfe_man_i(dfe_man_i),
    .dfe_coef_o(dfe_coef_o),
    .out_sel_i(out_sel_i),
    .chk_en_i(chk_en_i),
    .chk_err_cnt_o(chk_err_cnt_o),
    .cal_tick_i(cal_tick_i),
    .rate_sel_i(rate_sel_i),
    .rate_man_en_i(rate_man_en_i),
    .rate_man_cnt_i(rate_man_cnt_i),
    .ppm_cnt_o(ppm_cnt_o),
    .lock_o(lock_o),
    .fir_coef_i(fir_coef_i)
  );
  lec_rx_model rx (.clk_i(sys_clk_i), .srst_i(srst_i), .stall_i(stall),
    .valid_i(out_valid_o), .word_i(out_word_o), .ready_o(out_ready_i));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // Saturating the most negative codes keeps the taps symmetric
  function automatic int lvl(input logic b0, input logic b1, input logic b2);
    int pr, mn, po;
    pr = (fir_coef_i.pre == 5'sh10) ? -15 : fir_coef_i.pre;
    mn = (fir_coef_i.main == 6'sh20) ? -31 : fir_coef_i.main;
    po = (fir_coef_i.post == 5'sh10) ? -15 : fir_coef_i.post;
    return (b0 ? pr : -pr) + (b1 ? mn : -mn) + (b2 ? po : -po);
  endfunction : lvl
  task automatic push(input logic b);
    int k;
    logic t;
    in_valid_i = 1'b1;
    // Large enough that a few adapted tap codes cannot flip a decision
    in_sample_i = b ? 10'sd200 : -10'sd200;
    for (k = 0; k < 20 && in_ready_o !== 1'b1; k++) @(negedge sys_clk_i);
    if (in_ready_o !== 1'b1) begin
      chk("in_ready_o wait", 16'h0, 16'h1);
      summarize();
    end
    t = b;
    if (out_sel_i == lec_pkg::LEC_OSEL_PRBS) begin
      t = pq[6] ^ pq[5];
      pq = {pq[5:0], t};
    end else if (out_sel_i == lec_pkg::LEC_OSEL_MUTE) begin
      t = 1'b0;
    end
    lq.push_back(out_sel_i == lec_pkg::LEC_OSEL_MUTE ? 0 : lvl(t, h1, h2));
    bq.push_back(h1);
    h2 = h1;
    h1 = t;
    pend++;
    @(negedge sys_clk_i);
  endtask : push
  task automatic burst(input logic [7:0] pat, input string nm);
    int i;
    for (i = 0; i < 8; i++) push(pat[i]);
    in_valid_i = 1'b0;
    for (i = 0; i < 20 && out_valid_o !== 1'b0; i++) @(negedge sys_clk_i);
    if (out_valid_o !== 1'b0) begin
      chk("out_valid_o drain", {15'h0, out_valid_o}, 16'h0);
      summarize();
    end
    chk("word count", 16'(rx.got.size()), 16'(lq.size()));
    for (i = 0; i < lq.size() && i < rx.got.size(); i++) begin
      chk("level", 16'(rx.got[i].level), 16'(lq[i]));
      chk("bit_val", {15'h0, rx.got[i].bit_val}, {15'h0, bq[i]});
    end
    $display("test %s done", nm);
    rx.got.delete();
    lq.delete();
    bq.delete();
  endtask : burst
  task automatic window(input logic man, input logic exp_lock);
    int i;
    rate_man_en_i = man;
    for (i = 0; i < 1030; i++) begin
      cal_tick_i = (i < 1024);
      in_valid_i = i[0];
      @(negedge sys_clk_i);
    end
    chk("ppm_cnt_o", ppm_cnt_o, 16'(pend + 512));
    chk("lock_o", {15'h0, lock_o}, {15'h0, exp_lock});
    // Pushes on steps 1025, 1027 and 1029 fall into the next window
    pend = 3;
    $display("test rate window done");
    rx.got.delete();
  endtask : window
  initial begin
    repeat (8) @(negedge sys_clk_i);
    chk("in_ready_o in reset", {15'h0, in_ready_o}, 16'h0);
    srst_i = 1'b0;
    fir_coef_i = {-5'sd3, 6'sd20, -5'sd5};
    stall = 1'b1;
    push(1'b1);
    push(1'b0);
    in_valid_i = 1'b0;
    chk("in_ready_o full", {15'h0, in_ready_o}, 16'h0);
    repeat (2) @(negedge sys_clk_i);
    stall = 1'b0;
    burst(8'hB4, "stall, boost, equalizer disabled");
    fir_coef_i = {5'sd4, 6'sd10, 5'sd6};
    dfe_en_i = 1'b1;
    dfe_level_i = lec_pkg::LEC_DFE_OFF;
    burst(8'h3C, "attenuate, no taps");
    chk("tap1 coef", {10'h0, dfe_coef_o[0]}, 16'h0021);
    chk("tap2 coef", {10'h0, dfe_coef_o[1]}, 16'h000F);
    chk("tap5 coef", {10'h0, dfe_coef_o[4]}, 16'h0031);
    fir_coef_i = {5'sh10, 6'sh20, 5'sh0F};
    burst(8'h96, "saturated coefficients");
    for (int k = 1; k < 4; k++) begin
      out_sel_i = lec_pkg::lec_osel_t'(k);
      burst(8'h5A, "output select");
    end
    out_sel_i = lec_pkg::LEC_OSEL_RETIMED;
    // Seven ones seed the checker history, then a clean sequence continues it
    burst(8'hFF, "checker seed");
    chk_en_i = 1'b1;
    burst(8'h40, "checker clean");
    burst(8'h30, "checker clean");
    chk("chk_err_cnt_o clean", chk_err_cnt_o, 16'h0000);
    burst(8'h00, "checker errors");
    chk("chk_err_cnt_o errors", chk_err_cnt_o, 16'h0002);
    chk_en_i = 1'b0;
    dfe_man_i = '0;
    dfe_level_i = lec_pkg::LEC_DFE_T12;
    burst(8'hFF, "equalizer manual zero");
    dfe_adapt_i = lec_pkg::LEC_AD_CONT;
    // Error stays positive for eight steps, so each active tap walks down by one code per step, to -8
    burst(8'hFF, "equalizer adapt");
    chk("tap1 adapt", {10'h0, dfe_coef_o[0]}, 16'h0038);
    chk("tap2 adapt", {10'h0, dfe_coef_o[1]}, 16'h0038);
    chk("tap3 idle", {10'h0, dfe_coef_o[2]}, 16'h0000);
    dfe_en_i = 1'b0;
    @(negedge sys_clk_i);
    chk("tap1 disabled", {10'h0, dfe_coef_o[0]}, 16'h0000);
    dfe_adapt_i = lec_pkg::LEC_AD_OFF;
    // Count since reset still holds every earlier push, so no lock yet
    window(1'b0, 1'b0);
    window(1'b0, 1'b1);
    window(1'b1, 1'b0);
    rate_sel_i = 2'h1;
    window(1'b0, 1'b0);
    in_valid_i = 1'b0;
    summarize();
  end
endmodule : tb
`default_nettype wire
